/* pmt_map.svh */
// Purpose: Register map, field positions and timing constants of the activity mode timer
// Assumes: Included by its bare name from every module file of the block
// Notes:   Register indices are printed indices; byte address is four times the index
//
// Function
// - IRQ lines 8-11,13-15 join group by mask
// - IRQ 1,3,4,12 only count as input-device
// - DRQ 0-3,5-7 by mask; bit4 selects PCI master
// - Time base 00=1s 01=10s 10=1min 11=10min
// - Run bit low holds counter cleared
// - Bit 3 selects counter or setting readback
// - Timeout equals count field times time base
// - Count field zero means sixteen units
// - Doubling control doubles the timeout period
// - Event-select bit 7 doubles timer time base
// - Mode timer expiry reports cause code 0001
`ifndef PMT_MAP_SVH
`define PMT_MAP_SVH

// ------------------------------------------------------------
// Register indices
// ------------------------------------------------------------
`define PMT_IDX_EVT_SEL 8'h34
`define PMT_IDX_CAUSE 8'h35
`define PMT_IDX_IRQ_SEL 8'h37
`define PMT_IDX_DRQ_SEL 8'h38
`define PMT_IDX_MODE_SET 8'h39
`define PMT_IDX_INT_STAT 8'h40
`define PMT_IDX_INT_MASK 8'h41
`define PMT_IDX_MSB 9
`define PMT_IDX_LSB 2

// ------------------------------------------------------------
// Field positions and codes
// ------------------------------------------------------------
`define PMT_EVT_DOUBLE_BIT 7
`define PMT_MODE_RUN_BIT 2
`define PMT_MODE_RDCUR_BIT 3
`define PMT_IRQ_RSVD_BIT 4
`define PMT_DRQ_PCI_BIT 4
`define PMT_IRQ_LINE_BASE 8
`define PMT_INDEV_LINES 16'h101A
`define PMT_IRQ_GRP_LINES 16'hEF00
`define PMT_CNT_FULL 5'h10
`define PMT_CAUSE_NONE 4'h0
`define PMT_CAUSE_MODE 4'h1
`define PMT_CAUSE_IRQ 4'h6
`define PMT_CAUSE_DRQ 4'h7
`define PMT_ST_TIMEOUT 0
`define PMT_ST_IRQ 1
`define PMT_ST_DRQ 2
`define PMT_TB_1S 2'h0
`define PMT_TB_10S 2'h1
`define PMT_TB_1MIN 2'h2
`define PMT_TB_10MIN 2'h3

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define PMT_SECOND_NS 1000000000
`define PMT_CLK_PERIOD_NS 25
`define PMT_BASE_1S 1
`define PMT_BASE_10S 10
`define PMT_BASE_1MIN 60
`define PMT_BASE_10MIN 600
`define PMT_HTRANS_NONSEQ 2'h2
`define PMT_HSIZE_WORD 3'h2

`endif

/* pmt_pkg.sv */
// Purpose: State types of the activity mode timer modules
// Assumes: Constants live in pmt_map.svh
// Notes:   One packed struct per module holds all of its state
`default_nettype none
package pmt_pkg;
    typedef struct packed {
        logic wr_pend;
        logic [7:0] widx;
        logic [31:0] hrdata;
    } pmt_ahb_type;

    typedef struct packed {
        logic [25:0] sec_cnt;
        logic [10:0] unit_cnt;
        logic tick;
    } pmt_tb_type;

    typedef struct packed {
        logic [7:0] irq_sel;
        logic [7:0] drq_sel;
        logic [7:0] mode_set;
        logic evt_double;
        logic [2:0] status;
        logic [2:0] mask;
        logic [3:0] cause;
        logic [4:0] count;
        logic [15:0] irq_s1;
        logic [15:0] irq_s2;
        logic [7:0] drq_s1;
        logic [7:0] drq_s2;
        logic pci_s1;
        logic pci_s2;
        logic irq_grp;
        logic drq_grp;
        logic in_dev;
        logic timeout;
        logic pm_irq;
    } pmt_core_type;
endpackage
`default_nettype wire

/* pmt_if.sv */
// Purpose: Carriers between the register slave, the time base and the core
// Assumes: Single clock domain
// Notes:   Register access uses indices, not byte addresses
`timescale 1ns/1ps
`default_nettype none
interface pmt_reg_if;
    logic wr;
    logic [7:0] widx;
    logic [7:0] wdata;
    logic [7:0] ridx;
    logic [7:0] rdata;
    modport slv(output wr, output widx, output wdata, output ridx, input rdata);
    modport core(input wr, input widx, input wdata, input ridx, output rdata);
endinterface

interface pmt_tick_if;
    logic run;
    logic [1:0] base_sel;
    logic dbl;
    logic tick;
    modport ctl(output run, output base_sel, output dbl, input tick);
    modport gen(input run, input base_sel, input dbl, output tick);
endinterface
`default_nettype wire

/* pmt_ahb_slave.sv */
// Purpose: AHB-Lite slave turning word transfers into register index accesses
// Assumes: Single word transfers, response always OKAY
// Notes:   Zero wait states; write lands at the data-phase edge
`timescale 1ns/1ps
`default_nettype none
`include "pmt_map.svh"
module pmt_ahb_slave (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    pmt_reg_if.slv rb
);
    import pmt_pkg::*;
    pmt_ahb_type st;
    pmt_ahb_type next_st;
    logic take;
    logic in_map;

    // ------------------------------------------------------------
    // Address phase decode
    // ------------------------------------------------------------
    // Addresses above the index field never alias onto registers
    assign in_map = (haddr[31:`PMT_IDX_MSB+1] == '0) && (hsize == `PMT_HSIZE_WORD);
    assign take = hsel && hready && (htrans == `PMT_HTRANS_NONSEQ);
    assign rb.ridx = haddr[`PMT_IDX_MSB:`PMT_IDX_LSB];

    // Read data sampled at the address edge, write held for the data phase
    always_comb begin
        next_st = st;
        next_st.wr_pend = 1'b0;
        if (take) begin
            next_st.wr_pend = hwrite && in_map;
            next_st.widx = haddr[`PMT_IDX_MSB:`PMT_IDX_LSB];
            next_st.hrdata = (!hwrite && in_map) ? {24'h000000, rb.rdata} : '0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rb.wr = st.wr_pend;
    assign rb.widx = st.widx;
    assign rb.wdata = hwdata[7:0];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = st.hrdata;
endmodule
`default_nettype wire

/* pmt_time_base.sv */
// Purpose: Seconds prescaler and selectable time-base unit tick
// Assumes: SEC_CYCLES clock cycles make one second
// Notes:   Run low clears both stages so a restart counts a full unit
`timescale 1ns/1ps
`default_nettype none
`include "pmt_map.svh"
module pmt_time_base #(
    parameter int unsigned SEC_CYCLES = `PMT_SECOND_NS / `PMT_CLK_PERIOD_NS
) (
    input wire logic ref_clk,
    input wire logic rst,
    pmt_tick_if.gen tk
);
    import pmt_pkg::*;
    pmt_tb_type st;
    pmt_tb_type next_st;
    logic [10:0] lim;

    // ------------------------------------------------------------
    // Unit selection and counting
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.tick = 1'b0;
        unique case (tk.base_sel)
            `PMT_TB_1S: lim = 11'(`PMT_BASE_1S);
            `PMT_TB_10S: lim = 11'(`PMT_BASE_10S);
            `PMT_TB_1MIN: lim = 11'(`PMT_BASE_1MIN);
            `PMT_TB_10MIN: lim = 11'(`PMT_BASE_10MIN);
        endcase
        // Doubling the unit doubles every timeout period
        if (tk.dbl) begin
            lim = {lim[9:0], 1'b0};
        end
        if (!tk.run) begin
            next_st.sec_cnt = '0;
            next_st.unit_cnt = '0;
        end else if (st.sec_cnt == 26'(SEC_CYCLES - 1)) begin
            next_st.sec_cnt = '0;
            if (st.unit_cnt == lim - 11'h001) begin
                next_st.unit_cnt = '0;
                next_st.tick = 1'b1;
            end else begin
                next_st.unit_cnt = st.unit_cnt + 11'h001;
            end
        end else begin
            next_st.sec_cnt = st.sec_cnt + 26'h0000001;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tk.tick = st.tick;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_unit_length: assert property (@(posedge ref_clk) disable iff (rst)
        st.tick |-> ($past(st.unit_cnt) == $past(lim) - 11'h001))
        else $error("unit tick at wrong second count");
    a_double_unit: assert property (@(posedge ref_clk) disable iff (rst)
        (tk.dbl && tk.base_sel == `PMT_TB_10S) |-> (lim == 11'(2 * `PMT_BASE_10S)))
        else $error("doubled unit not twice the base");
endmodule
`default_nettype wire

/* pmt_top.sv */
// Purpose: Activity group selection and mode timer with AHB-Lite registers
// Assumes: Activity pins are asynchronous; one 40 MHz clock
// Notes:   Status bits are write-one-to-clear; a new event beats its clear
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "pmt_map.svh"
module pmt_top #(
    parameter int unsigned SEC_CYCLES = `PMT_SECOND_NS / `PMT_CLK_PERIOD_NS
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [15:0] irq_line,
    input wire logic [7:0] drq_line,
    input wire logic pci_master_active,
    output logic irq_group_active,
    output logic drq_group_active,
    output logic input_device_active,
    output logic mode_timeout,
    output logic [3:0] smi_cause,
    output logic pm_irq
);
    import pmt_pkg::*;

    pmt_core_type st;
    pmt_core_type next_st;
    logic [7:0] irq_hit;
    logic [7:0] drq_hit;
    logic [4:0] target;
    logic [4:0] count_inc;
    logic [2:0] events;
    logic [7:0] rdata;

    pmt_reg_if rb();
    pmt_tick_if tk();

    // ------------------------------------------------------------
    // Bus slave and time base
    // ------------------------------------------------------------
    pmt_ahb_slave u_bus (
        .ref_clk(ref_clk),
        .rst(rst),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .rb(rb.slv)
    );

    pmt_time_base #(
        .SEC_CYCLES(SEC_CYCLES)
    ) u_base (
        .ref_clk(ref_clk),
        .rst(rst),
        .tk(tk.gen)
    );

    // Timer controls straight from the setting and event-select registers
    assign tk.run = st.mode_set[`PMT_MODE_RUN_BIT];
    assign tk.base_sel = st.mode_set[1:0];
    assign tk.dbl = st.evt_double;

    // ------------------------------------------------------------
    // Group membership per mask bit
    // ------------------------------------------------------------
    // Mask bit b covers IRQ line 8+b; line 12 is never a group member
    genvar b;
    generate
        for (b = 0; b < 8; b++) begin : g_sel
            if (b == `PMT_IRQ_RSVD_BIT) begin : g_rsvd
                assign irq_hit[b] = 1'b0;
            end else begin : g_irq
                assign irq_hit[b] = st.irq_sel[b] && st.irq_s2[`PMT_IRQ_LINE_BASE + b];
            end
            if (b == `PMT_DRQ_PCI_BIT) begin : g_pci
                assign drq_hit[b] = st.drq_sel[b] && st.pci_s2;
            end else begin : g_drq
                assign drq_hit[b] = st.drq_sel[b] && st.drq_s2[b];
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Timeout target
    // ------------------------------------------------------------
    // A zero count field stands for sixteen units
    assign target = (st.mode_set[7:4] == 4'h0) ? `PMT_CNT_FULL : {1'b0, st.mode_set[7:4]};
    assign count_inc = st.count + 5'h01;

    // ------------------------------------------------------------
    // Register readback
    // ------------------------------------------------------------
    always_comb begin
        rdata = 8'h00;
        unique case (rb.ridx)
            `PMT_IDX_EVT_SEL: rdata = {st.evt_double, 7'h00};
            `PMT_IDX_CAUSE: rdata = {4'h0, st.cause};
            `PMT_IDX_IRQ_SEL: rdata = {st.irq_sel[7:5], 1'b0, st.irq_sel[3:0]};
            `PMT_IDX_DRQ_SEL: rdata = st.drq_sel;
            `PMT_IDX_MODE_SET: begin
                // Live count or programmed setting in the upper nibble
                if (st.mode_set[`PMT_MODE_RDCUR_BIT]) begin
                    rdata = {st.count[3:0], st.mode_set[3:0]};
                end else begin
                    rdata = st.mode_set;
                end
            end
            `PMT_IDX_INT_STAT: rdata = {5'h00, st.status};
            `PMT_IDX_INT_MASK: rdata = {5'h00, st.mask};
            default: rdata = 8'h00;
        endcase
    end
    assign rb.rdata = rdata;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        // Pins pass two flops before any logic looks at them
        next_st.irq_s1 = irq_line;
        next_st.irq_s2 = st.irq_s1;
        next_st.drq_s1 = drq_line;
        next_st.drq_s2 = st.drq_s1;
        next_st.pci_s1 = pci_master_active;
        next_st.pci_s2 = st.pci_s1;
        next_st.irq_grp = |irq_hit;
        next_st.drq_grp = |drq_hit;
        next_st.in_dev = |(st.irq_s2 & `PMT_INDEV_LINES);
        next_st.timeout = 1'b0;

        // Register writes land in the data phase
        if (rb.wr) begin
            unique case (rb.widx)
                `PMT_IDX_EVT_SEL: next_st.evt_double = rb.wdata[`PMT_EVT_DOUBLE_BIT];
                `PMT_IDX_IRQ_SEL: next_st.irq_sel = rb.wdata;
                `PMT_IDX_DRQ_SEL: next_st.drq_sel = rb.wdata;
                `PMT_IDX_MODE_SET: next_st.mode_set = rb.wdata;
                `PMT_IDX_INT_STAT: next_st.status = st.status & ~rb.wdata[2:0];
                `PMT_IDX_INT_MASK: next_st.mask = rb.wdata[2:0];
                default: next_st.status = next_st.status;
            endcase
        end

        // Counter steps once per unit and wraps at the target
        if (!st.mode_set[`PMT_MODE_RUN_BIT]) begin
            next_st.count = '0;
        end else if (tk.tick) begin
            if (count_inc == target) begin
                next_st.count = '0;
                next_st.timeout = 1'b1;
            end else begin
                next_st.count = count_inc;
            end
        end

        // Events: timer expiry and rising group activity, built here so no loop through next_st
        events = {next_st.drq_grp && !st.drq_grp,
                  next_st.irq_grp && !st.irq_grp,
                  next_st.timeout};

        // Sticky events; a set in the clearing cycle wins
        next_st.status = next_st.status | events;
        if (events[`PMT_ST_TIMEOUT]) begin
            next_st.cause = `PMT_CAUSE_MODE;
        end else if (events[`PMT_ST_IRQ]) begin
            next_st.cause = `PMT_CAUSE_IRQ;
        end else if (events[`PMT_ST_DRQ]) begin
            next_st.cause = `PMT_CAUSE_DRQ;
        end
        next_st.pm_irq = |(next_st.status & next_st.mask);
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign irq_group_active = st.irq_grp;
    assign drq_group_active = st.drq_grp;
    assign input_device_active = st.in_dev;
    assign mode_timeout = st.timeout;
    assign smi_cause = st.cause;
    assign pm_irq = st.pm_irq;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // Last unit of a running period
    sequence s_last_unit;
        st.mode_set[`PMT_MODE_RUN_BIT] && tk.tick && (count_inc == target);
    endsequence

    // Expiry seen at the outputs
    sequence s_fire;
        mode_timeout && (st.count == 5'h00) && (smi_cause == `PMT_CAUSE_MODE);
    endsequence

    a_irq_group_mask: assert property (
        (st.irq_sel[0] && st.irq_s2[`PMT_IRQ_LINE_BASE]) |=> irq_group_active)
        else $error("selected irq8 not in irq group");
    a_input_dev_excl: assert property (
        ((st.irq_s2 & `PMT_IRQ_GRP_LINES) == 16'h0000) |=> !irq_group_active)
        else $error("input device line reached irq group");
    a_drq_pci_bit: assert property (
        (st.drq_sel[`PMT_DRQ_PCI_BIT] && st.pci_s2) |=> drq_group_active)
        else $error("pci master not in drq group");
    a_counter_held: assert property (
        !st.mode_set[`PMT_MODE_RUN_BIT] |=> (st.count == 5'h00) && !mode_timeout)
        else $error("stopped counter not cleared");
    a_readback_sel: assert property (
        (rb.ridx == `PMT_IDX_MODE_SET && st.mode_set[`PMT_MODE_RDCUR_BIT])
        |-> (rdata[7:4] == st.count[3:0]))
        else $error("readback not showing live count");
    a_timeout_fire: assert property (
        s_last_unit |=> s_fire)
        else $error("timer did not expire at target");
    a_zero_sixteen: assert property (
        (mode_timeout && $past(st.mode_set[7:4]) == 4'h0) |-> ($past(st.count) == 5'h0F))
        else $error("zero setting not sixteen units");
    a_no_early_fire: assert property (
        (tk.tick && st.mode_set[`PMT_MODE_RUN_BIT] && count_inc != target) |=> !mode_timeout)
        else $error("timeout before target");
    a_cause_code: assert property (
        $rose(mode_timeout) |-> (smi_cause == `PMT_CAUSE_MODE) ##1 !mode_timeout)
        else $error("mode timeout cause code wrong");
    a_double_write: assert property (
        (rb.wr && rb.widx == `PMT_IDX_EVT_SEL) |=> (tk.dbl == $past(rb.wdata[`PMT_EVT_DOUBLE_BIT])))
        else $error("doubling control not reaching time base");
endmodule
`default_nettype wire

/* tb.sv */
// Purpose: Self-checking bench for the activity mode timer over AHB-Lite
// Assumes: SEC_CYCLES shortened to 4, so one second of time base is 4 clock cycles
// Notes:   Inputs change by NBA after a rising edge; outputs are sampled on the falling edge after settle, at the rising edge after a bus transfer
`timescale 1ns/1ps
`default_nettype none
`include "pmt_map.svh"
module tb;
    localparam int SEC = 4;
    logic ref_clk;
    logic rst;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [31:0] hwdata;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic [15:0] irq_line;
    logic [7:0] drq_line;
    logic pci_master_active;
    logic irq_group_active;
    logic drq_group_active;
    logic input_device_active;
    logic mode_timeout;
    logic [3:0] smi_cause;
    logic pm_irq;
    logic [31:0] d;
    int n_errors;
    int n_tests;
    int units[4] = '{`PMT_BASE_1S, `PMT_BASE_10S, `PMT_BASE_1MIN, `PMT_BASE_10MIN};
    int lines[7] = '{8, 9, 10, 11, 13, 14, 15};

    // Single slave, so its ready is the bus ready
    pmt_top #(.SEC_CYCLES(SEC)) u_dut (
        .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(`PMT_HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq_line(irq_line),
        .drq_line(drq_line), .pci_master_active(pci_master_active),
        .irq_group_active(irq_group_active), .drq_group_active(drq_group_active),
        .input_device_active(input_device_active), .mode_timeout(mode_timeout),
        .smi_cause(smi_cause), .pm_irq(pm_irq)
    );

    // ------------------------------------------------------------
    // Clock and watchdog
    // ------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // Tests need about 3300 cycles; six times that is a hang
    initial begin
        #(25 * 20000);
        n_errors++;
        report_and_stop();
    end

    // ------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
            n_errors++;
        end
    endtask

    // One single transfer; waits on ready rather than assuming zero wait states
    task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= addr;
        hwrite <= wr;
        htrans <= `PMT_HTRANS_NONSEQ;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        logic [31:0] x;
        bus(1'b1, {22'h0, idx, 2'h0}, {24'h0, v}, x);
    endtask

    task automatic rchk(input string nm, input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] x;
        bus(1'b0, {22'h0, idx, 2'h0}, 32'h0, x);
        chk(nm, {24'h0, exp}, x);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    // Start the timer, count cycles from the write edge to the pulse, then stop it
    task automatic run_to(input logic [7:0] setv, input int exp_n);
        int n;
        n = 0;
        wr(`PMT_IDX_MODE_SET, setv);
        // First falling edge lies in the write cycle itself, zero edges after it
        @(negedge ref_clk);
        while (mode_timeout !== 1'b1 && n < 6000) begin
            @(negedge ref_clk);
            n++;
        end
        chk("cycles to timeout", exp_n, n);
        wr(`PMT_IDX_MODE_SET, 8'h00);
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        irq_line = 16'h0;
        drq_line = 8'h0;
        pci_master_active = 1'b0;
        n_errors = 0;
        n_tests = 0;
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        // Reset values, unmapped address and response code
        rchk("irq select reset", `PMT_IDX_IRQ_SEL, 8'h00);
        rchk("drq select reset", `PMT_IDX_DRQ_SEL, 8'h00);
        rchk("mode setting reset", `PMT_IDX_MODE_SET, 8'h00);
        bus(1'b0, 32'h0000_04E4, 32'h0, d);
        chk("unmapped read", 32'h0, d);
        chk("response", 32'h0, {31'h0, hresp});
        chk("ready", 32'h1, {31'h0, hreadyout});
        $display("test registers done");
        // Every time base with a count of one, then the count boundaries
        for (int b = 0; b < 4; b++) begin
            run_to({4'h1, 2'b01, 2'(b)}, units[b] * SEC + 1);
        end
        run_to(8'h04, 16 * SEC + 1);
        run_to(8'hF4, 15 * SEC + 1);
        wr(`PMT_IDX_EVT_SEL, 8'h80);
        run_to(8'h15, 2 * `PMT_BASE_10S * SEC + 1);
        wr(`PMT_IDX_EVT_SEL, 8'h00);
        rchk("cause after expiry", `PMT_IDX_CAUSE, {4'h0, `PMT_CAUSE_MODE});
        chk("cause output", {28'h0, `PMT_CAUSE_MODE}, {28'h0, smi_cause});
        $display("test timer periods done");
        // Sticky status, mask gating and write-one-to-clear
        rchk("status after expiry", `PMT_IDX_INT_STAT, 8'h01);
        settle(1);
        chk("masked interrupt", 32'h0, {31'h0, pm_irq});
        wr(`PMT_IDX_INT_MASK, 8'h01);
        settle(1);
        chk("unmasked interrupt", 32'h1, {31'h0, pm_irq});
        wr(`PMT_IDX_INT_STAT, 8'h01);
        settle(1);
        chk("cleared interrupt", 32'h0, {31'h0, pm_irq});
        $display("test interrupt done");
        // Live count versus setting readback; run low clears the count
        wr(`PMT_IDX_MODE_SET, 8'hFC);
        settle(10);
        bus(1'b0, {22'h0, `PMT_IDX_MODE_SET, 2'h0}, 32'h0, d);
        chk("live count in range", 32'h1, {31'h0, d[7:4] >= 4'h1 && d[7:4] <= 4'h4});
        chk("live low bits", 32'hC, {28'h0, d[3:0]});
        wr(`PMT_IDX_MODE_SET, 8'hF8);
        rchk("stopped count", `PMT_IDX_MODE_SET, 8'h08);
        wr(`PMT_IDX_MODE_SET, 8'hF0);
        rchk("setting readback", `PMT_IDX_MODE_SET, 8'hF0);
        $display("test readback done");
        // IRQ group: reserved bit, input-device lines, one selected line at a time
        wr(`PMT_IDX_INT_STAT, 8'h07);
        wr(`PMT_IDX_IRQ_SEL, 8'hFF);
        rchk("irq select reserved", `PMT_IDX_IRQ_SEL, 8'hEF);
        irq_line <= `PMT_INDEV_LINES;
        settle(4);
        chk("irq group from input lines", 32'h0, {31'h0, irq_group_active});
        chk("input device active", 32'h1, {31'h0, input_device_active});
        for (int i = 0; i < 7; i++) begin
            @(posedge ref_clk);
            irq_line <= 16'h0;
            wr(`PMT_IDX_IRQ_SEL, 8'(8'h01 << (lines[i] - 8)));
            irq_line <= ~(16'h0001 << lines[i]);
            settle(4);
            chk("irq group unselected lines", 32'h0, {31'h0, irq_group_active});
            @(posedge ref_clk);
            irq_line <= 16'h0001 << lines[i];
            settle(4);
            chk("irq group selected line", 32'h1, {31'h0, irq_group_active});
        end
        rchk("cause irq", `PMT_IDX_CAUSE, {4'h0, `PMT_CAUSE_IRQ});
        rchk("status irq", `PMT_IDX_INT_STAT, 8'h02);
        $display("test irq group done");
        // DRQ group: each channel and the PCI master, with all others active
        for (int b = 0; b < 8; b++) begin
            @(posedge ref_clk);
            drq_line <= 8'h00;
            pci_master_active <= 1'b0;
            wr(`PMT_IDX_DRQ_SEL, 8'(8'h01 << b));
            drq_line <= ~(8'h01 << b);
            pci_master_active <= (b != 4);
            settle(4);
            chk("drq group unselected", 32'h0, {31'h0, drq_group_active});
            @(posedge ref_clk);
            drq_line <= (b == 4) ? 8'h00 : 8'(8'h01 << b);
            pci_master_active <= (b == 4);
            settle(4);
            chk("drq group selected", 32'h1, {31'h0, drq_group_active});
        end
        rchk("cause drq", `PMT_IDX_CAUSE, {4'h0, `PMT_CAUSE_DRQ});
        chk("cause output drq", {28'h0, `PMT_CAUSE_DRQ}, {28'h0, smi_cause});
        $display("test drq group done");
        report_and_stop();
    end
endmodule
`default_nettype wire
